// File: shared/pwc_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  power, wake-up and interrupt control block.
  Assumes a 40 MHz system clock; included by the design.
*/
// Functional notes
// - Host sets saving bit; activity, port access or wake frame ends it.
// - Power status output is high exactly during zero-power mode.
// - Receiver power output low when receiver must be powered, else high.
// - As timing master, wake request starts a wake-up frame transmission.
// - Low-power keeps only transceiver and wake-up logic running.
// - Entering low-power asserts the synchronous-data bypass bit.
// - Low-power exits on wake frame or two port edges or strobes.
// - Bypass bit stays set after low-power wake-up.
// - Low-power wake sets error, asserts interrupt, resets other state.
// - Zero-power enable enters low-power, then zero-power when quiet.
// - In zero-power only wake-up logic runs, watching the receive input.
// - Zero-power scans receive input every 50 ms, pulsing rx power low.
// - Zero-power exits on receive activity or two port edges or strobes.
// - Zero-power wake sets message error and raises power-on interrupt.
// - Interrupt output signals four event classes gated by enables.
// - Host clears pending events through message control clear bits.
// - Enable register bits 3..0 as listed, 7..4 reserved, reset zero.
// - Interrupt only when an enable and its status flag are both set, or the power-on flag is set.
// - Config-change flag sets when max position or max delay changes.
// - After reset or wake-up, interrupt goes low whatever error enable.
// - Clearing one of several pending events releases interrupt briefly.
// - Network activity flag set on receive edges, cleared seven clocks (175 ns) after the last.
`ifndef PWC_REGS_SVH
`define PWC_REGS_SVH

`define PWC_ADDR_IE        8'h88
`define PWC_ADDR_CPC       8'h8e
`define PWC_ADDR_MSGC      8'h85
`define PWC_ADDR_MSGS      8'h86
`define PWC_ADDR_XCR       8'h80
`define PWC_ADDR_MPR       8'ha0
`define PWC_ADDR_MDR       8'ha1
`define PWC_ADDR_PRESV     8'ha2

`define PWC_IE_MASK        8'h0f
`define PWC_IE_RESET       8'h00
`define PWC_BIT_ALC        3
`define PWC_BIT_ERR        2
`define PWC_BIT_MTX        1
`define PWC_BIT_MRX        0
`define PWC_BIT_NAC        6
`define PWC_BIT_ZP         5
`define PWC_BIT_LP         4
`define PWC_BIT_LPW        1
`define PWC_BIT_SBY        0
`define PWC_BIT_MTR        7
`define PWC_BIT_PON        4

`define PWC_CLK_HZ         40000000
`define PWC_NAC_NS         128
`define PWC_NAC_CYC        (((`PWC_NAC_NS * 40) + 999) / 1000)
`define PWC_SCAN_MS        50
`define PWC_SCAN_CYC       ((`PWC_SCAN_MS * (`PWC_CLK_HZ / 1000)))
`define PWC_PULSE_US       150
`define PWC_PULSE_CYC      ((`PWC_PULSE_US * (`PWC_CLK_HZ / 1000000)))
`define PWC_WAKE_CYC       16

`endif

// File: shared/pwc_pkg.sv
/*
  Types of the power, wake-up and interrupt control block.
  Assumes nothing beyond the register header.
*/
`default_nettype none

package pwc_pkg;

  typedef enum logic [2:0] {
    PWC_RUN,
    PWC_LOW,
    PWC_WAIT_QUIET,
    PWC_ZERO,
    PWC_SCAN,
    PWC_WAKE
  } pwc_mode_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pwc_bus_s;

  typedef struct packed {
    logic alc;
    logic err;
    logic mtx;
    logic mrx;
  } pwc_flags_s;

endpackage

`default_nettype wire

// File: rtl/pwc_edge_count.sv
/*
  Counts qualifying falling edges of one control port line.
  Assumes the line has already been synchronised to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pwc_edge_count (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_clear,
  input  wire logic i_line,
  output var  logic o_two
);

  logic       line_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  wire        fall = line_q & ~i_line;

  assign cnt_d = i_clear ? 2'h0 :
                 (fall && cnt_q != 2'h2) ? cnt_q + 2'h1 : cnt_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      line_q <= 1'b1;
      cnt_q  <= 2'h0;
      o_two  <= 1'b0;
    end else begin
      line_q <= i_line;
      cnt_q  <= cnt_d;
      o_two  <= (cnt_d == 2'h2);
    end
  end

endmodule

`default_nettype wire

// File: rtl/pwc_power_ctrl.sv
/*
  Power-saving modes, wake-up detection and active-low host interrupt.
  Assumes a byte register port already decoded from the control port,
  event strobes from the message engine and a synchronous host.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwc_regs.svh"

module pwc_power_ctrl (
  input  wire logic              I_CLOCK,
  input  wire logic              I_RST_B,
  input  wire pwc_pkg::pwc_bus_s I_BUS,
  input  wire logic              I_RX,
  input  wire logic              I_SDA,
  input  wire logic              I_CS_B,
  input  wire logic              I_WR_B,
  input  wire logic [1:0]        I_PORT_MODE,
  input  wire logic              I_WAKE_FRAME_RX,
  input  wire logic              I_MSG_TX_DONE,
  input  wire logic              I_MSG_RX_DONE,
  input  wire logic              I_ERR_EVENT,
  input  wire logic [7:0]        I_MAX_POSITION,
  input  wire logic [7:0]        I_MAX_DELAY,
  output logic [7:0]             O_RDATA,
  output logic                   O_INT_B,
  output logic                   O_STATUS,
  output logic                   O_RX_POWER_B,
  output logic                   O_WAKE_FRAME_TX,
  output logic                   O_SECTION_EN,
  output logic                   O_TRANSCEIVER_EN,
  output logic                   O_SOFT_RESET,
  output logic                   O_SYNC_BYPASS
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [2:0] rx_s_q, sda_s_q, cs_s_q, wr_s_q;
  logic       rx_v_q, sda_v_q, cs_v_q, wr_v_q;

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rx_s_q  <= 3'h0;
      sda_s_q <= 3'h7;
      cs_s_q  <= 3'h7;
      wr_s_q  <= 3'h7;
      rx_v_q  <= 1'b0;
      sda_v_q <= 1'b1;
      cs_v_q  <= 1'b1;
      wr_v_q  <= 1'b1;
    end else begin
      rx_s_q  <= {rx_s_q[1:0], I_RX};
      sda_s_q <= {sda_s_q[1:0], I_SDA};
      cs_s_q  <= {cs_s_q[1:0], I_CS_B};
      wr_s_q  <= {wr_s_q[1:0], I_WR_B};
      if (rx_s_q[1] == rx_s_q[2])
        rx_v_q <= rx_s_q[2];
      if (sda_s_q[1] == sda_s_q[2])
        sda_v_q <= sda_s_q[2];
      if (cs_s_q[1] == cs_s_q[2])
        cs_v_q <= cs_s_q[2];
      if (wr_s_q[1] == wr_s_q[2])
        wr_v_q <= wr_s_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Network activity

  logic       rx_prev_q;
  logic [3:0] nac_cnt_q;
  logic       nac_q;
  wire        rx_edge = rx_prev_q ^ rx_v_q;

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rx_prev_q <= 1'b0;
      nac_cnt_q <= 4'h0;
      nac_q     <= 1'b0;
    end else begin
      rx_prev_q <= rx_v_q;
      if (rx_edge) begin
        nac_cnt_q <= 4'(`PWC_NAC_CYC);
        nac_q     <= 1'b1;
      end else if (nac_cnt_q != 4'h0) begin
        nac_cnt_q <= nac_cnt_q - 4'h1;
      end else begin
        nac_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]  ie_q;
  logic        lp_q, zp_q, lpw_q, sby_q, mtr_q;
  pwc_pkg::pwc_flags_s flags_q;
  logic        pon_q;
  logic [7:0]  mpr_q, mdr_q;
  logic        wake_done;
  wire         wr_ie   = I_BUS.wr && I_BUS.addr == `PWC_ADDR_IE;
  wire         wr_cpc  = I_BUS.wr && I_BUS.addr == `PWC_ADDR_CPC;
  wire         wr_msgc = I_BUS.wr && I_BUS.addr == `PWC_ADDR_MSGC;
  wire         wr_xcr  = I_BUS.wr && I_BUS.addr == `PWC_ADDR_XCR;
  wire [3:0]   clr     = wr_msgc ? I_BUS.wdata[3:0] : 4'h0;
  wire         clr_pon = wr_msgc && I_BUS.wdata[`PWC_BIT_PON];
  wire         cfg_chg = (mpr_q != I_MAX_POSITION) || (mdr_q != I_MAX_DELAY);
  wire [3:0]   ev      = {cfg_chg, I_ERR_EVENT | wake_done,
                          I_MSG_TX_DONE, I_MSG_RX_DONE};

  function automatic logic [3:0] flag_next(input logic [3:0] cur,
                                           input logic [3:0] set,
                                           input logic [3:0] cl);
    flag_next = set | (cur & ~cl);
  endfunction

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ie_q    <= `PWC_IE_RESET;
      lp_q    <= 1'b0;
      zp_q    <= 1'b0;
      lpw_q   <= 1'b0;
      sby_q   <= 1'b0;
      mtr_q   <= 1'b0;
      flags_q <= '0;
      pon_q   <= 1'b1;
      mpr_q   <= 8'h00;
      mdr_q   <= 8'h00;
    end else begin
      mpr_q <= I_MAX_POSITION;
      mdr_q <= I_MAX_DELAY;
      flags_q <= flag_next(flags_q, ev, clr);
      if (wake_done)
        pon_q <= 1'b1;
      else if (clr_pon)
        pon_q <= 1'b0;
      if (wake_done) begin
        ie_q  <= `PWC_IE_RESET;
        lp_q  <= 1'b0;
        zp_q  <= 1'b0;
        lpw_q <= 1'b0;
        mtr_q <= 1'b0;
      end else begin
        if (wr_ie)
          ie_q <= I_BUS.wdata & `PWC_IE_MASK;
        if (wr_cpc) begin
          lp_q <= I_BUS.wdata[`PWC_BIT_LP];
          zp_q <= I_BUS.wdata[`PWC_BIT_ZP];
        end
        if (wr_xcr) begin
          lpw_q <= I_BUS.wdata[`PWC_BIT_LPW];
          mtr_q <= I_BUS.wdata[`PWC_BIT_MTR];
        end else if (O_WAKE_FRAME_TX) begin
          lpw_q <= 1'b0;
        end
      end
      if (lp_q || zp_q)
        sby_q <= 1'b1;
      else if (wr_xcr)
        sby_q <= I_BUS.wdata[`PWC_BIT_SBY];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up edge detection

  pwc_pkg::pwc_mode_e mode_q, mode_d;
  logic  two_sda, two_cs, two_wr;
  wire   saving    = mode_q != pwc_pkg::PWC_RUN && mode_q != pwc_pkg::PWC_WAKE;
  wire   cnt_clear = !saving;

  pwc_edge_count u_sda (
    .i_clk   (I_CLOCK),
    .i_rst_b (I_RST_B),
    .i_clear (cnt_clear),
    .i_line  (sda_v_q),
    .o_two   (two_sda)
  );
  pwc_edge_count u_cs (
    .i_clk   (I_CLOCK),
    .i_rst_b (I_RST_B),
    .i_clear (cnt_clear),
    .i_line  (cs_v_q),
    .o_two   (two_cs)
  );
  pwc_edge_count u_wr (
    .i_clk   (I_CLOCK),
    .i_rst_b (I_RST_B),
    .i_clear (cnt_clear),
    .i_line  (wr_v_q),
    .o_two   (two_wr)
  );

  wire port_wake = (I_PORT_MODE == 2'h0 && two_sda) ||
                   (I_PORT_MODE == 2'h1 && two_cs) ||
                   (I_PORT_MODE == 2'h2 && two_wr);

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencer

  logic [20:0] tmr_q, tmr_d;
  assign wake_done = mode_q == pwc_pkg::PWC_WAKE && tmr_q == 21'h0;

  always_comb begin
    mode_d = mode_q;
    tmr_d  = (tmr_q != 21'h0) ? tmr_q - 21'h1 : 21'h0;
    case (mode_q)
      pwc_pkg::PWC_RUN: begin
        if (zp_q)
          mode_d = pwc_pkg::PWC_WAIT_QUIET;
        else if (lp_q)
          mode_d = pwc_pkg::PWC_LOW;
      end
      pwc_pkg::PWC_LOW, pwc_pkg::PWC_WAIT_QUIET: begin
        if (I_WAKE_FRAME_RX || port_wake) begin
          mode_d = pwc_pkg::PWC_WAKE;
          tmr_d  = 21'(`PWC_WAKE_CYC);
        end else if (mode_q == pwc_pkg::PWC_WAIT_QUIET && !nac_q) begin
          mode_d = pwc_pkg::PWC_ZERO;
          tmr_d  = 21'(`PWC_SCAN_CYC);
        end
      end
      pwc_pkg::PWC_ZERO: begin
        if (port_wake) begin
          mode_d = pwc_pkg::PWC_WAKE;
          tmr_d  = 21'(`PWC_WAKE_CYC);
        end else if (tmr_q == 21'h0) begin
          mode_d = pwc_pkg::PWC_SCAN;
          tmr_d  = 21'(`PWC_PULSE_CYC);
        end
      end
      pwc_pkg::PWC_SCAN: begin
        if (nac_q || port_wake) begin
          mode_d = pwc_pkg::PWC_WAKE;
          tmr_d  = 21'(`PWC_WAKE_CYC);
        end else if (tmr_q == 21'h0) begin
          mode_d = pwc_pkg::PWC_ZERO;
          tmr_d  = 21'(`PWC_SCAN_CYC);
        end
      end
      pwc_pkg::PWC_WAKE: begin
        if (tmr_q == 21'h0)
          mode_d = pwc_pkg::PWC_RUN;
      end
      default: mode_d = pwc_pkg::PWC_RUN;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      mode_q <= pwc_pkg::PWC_RUN;
      tmr_q  <= 21'h0;
    end else begin
      mode_q <= mode_d;
      tmr_q  <= tmr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt and outputs

  wire [3:0] gated = {flags_q.alc, flags_q.err, flags_q.mtx, flags_q.mrx}
                     & ie_q[3:0];
  wire       any_clr = |(clr & gated) || (clr_pon && pon_q);
  // release one clock on a clear
  wire       int_d = (|gated || pon_q) && !any_clr;

  wire zero_like = mode_q == pwc_pkg::PWC_ZERO || mode_q == pwc_pkg::PWC_SCAN;
  wire [7:0] cpc_rd = {1'b0, nac_q, zp_q, lp_q, 4'h0};

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_INT_B          <= 1'b1;
      O_STATUS         <= 1'b0;
      O_RX_POWER_B     <= 1'b0;
      O_WAKE_FRAME_TX  <= 1'b0;
      O_SECTION_EN     <= 1'b1;
      O_TRANSCEIVER_EN <= 1'b1;
      O_SOFT_RESET     <= 1'b0;
      O_SYNC_BYPASS    <= 1'b0;
      O_RDATA          <= 8'h00;
    end else begin
      O_INT_B <= !int_d;
      O_STATUS <= mode_d == pwc_pkg::PWC_ZERO || mode_d == pwc_pkg::PWC_SCAN;
      O_RX_POWER_B <= mode_d == pwc_pkg::PWC_ZERO;
      O_WAKE_FRAME_TX <= mtr_q && lpw_q && !O_WAKE_FRAME_TX;
      O_SECTION_EN <= mode_d == pwc_pkg::PWC_RUN;
      O_TRANSCEIVER_EN <= !(mode_d == pwc_pkg::PWC_ZERO ||
                            mode_d == pwc_pkg::PWC_SCAN);
      O_SOFT_RESET <= wake_done;
      O_SYNC_BYPASS <= sby_q;
      case (I_BUS.addr)
        `PWC_ADDR_IE:   O_RDATA <= ie_q;
        `PWC_ADDR_CPC:  O_RDATA <= cpc_rd;
        `PWC_ADDR_MSGS: O_RDATA <= {3'h0, pon_q, flags_q};
        `PWC_ADDR_XCR:  O_RDATA <= {mtr_q, 5'h0, lpw_q, sby_q};
        default:        O_RDATA <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  ie_resv_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    ie_q[7:4] == 4'h0) else $error("enable reserved bits set");
  status_zero_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    O_STATUS == zero_like) else $error("status not zero-power");
  rxpow_zero_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    mode_q == pwc_pkg::PWC_SCAN |-> !O_RX_POWER_B)
    else $error("receiver unpowered in scan");
  int_gate_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    (!(|gated) && !pon_q) |=> O_INT_B)
    else $error("interrupt without cause");
  int_gap_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    any_clr |=> O_INT_B) else $error("no release on clear");
  wake_pon_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    wake_done |=> pon_q && flags_q.err)
    else $error("wake did not flag");
  wake_int_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    wake_done |=> ##1 !O_INT_B) else $error("no wake interrupt");
  bypass_hold_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    (lp_q || zp_q) |=> sby_q) else $error("bypass not set");
  zp_entry_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    (mode_q == pwc_pkg::PWC_RUN && zp_q) |=>
      mode_q == pwc_pkg::PWC_WAIT_QUIET)
    else $error("zero-power entry skipped");
  cfg_flag_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    cfg_chg |=> flags_q.alc) else $error("config change lost");

endmodule

`default_nettype wire

// File: tb/pwc_ring_model.sv
/*
  Behavioural model of the ring that faces the power control block: drives
  the receive line and wake-frame arrivals, and counts wake frames sent.
  Assumes the bench steers it at the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module pwc_ring_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_active,
  input  wire logic       i_wake,
  input  wire logic       i_wake_tx,
  output var  logic       o_rx,
  output var  logic       o_wake_rx,
  output var  logic [7:0] o_frames
);
  logic wake_q;
  logic div_q;

  ////////////////////////////////////////////////////////////////////////////
  // Light toggles every second cycle while active, dark line otherwise;
  // a level must stand two cycles to pass the agreeing synchroniser.
  // Rising-edge updates keep clear of the bench's falling-edge steering.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx      <= 1'b0;
      div_q     <= 1'b0;
      wake_q    <= 1'b0;
      o_wake_rx <= 1'b0;
    end else begin
      div_q     <= i_active & ~div_q;
      o_rx      <= i_active & (o_rx ^ div_q);
      wake_q    <= i_wake;
      o_wake_rx <= i_wake & ~wake_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frames counted
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_frames <= 8'h00;
    end else if (i_wake_tx) begin
      o_frames <= o_frames + 8'h01;
    end
  end
endmodule

`default_nettype wire

// File: tb/tb.sv
/*
  Self-checking bench of the power, wake-up and interrupt control block.
  Assumes the block, its package and the ring model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic              clk;
  logic              rst_b;
  pwc_pkg::pwc_bus_s bus;
  logic              cs_b;
  logic              sda;
  logic              wr_b;
  logic [1:0]        port_mode;
  logic              tx_done;
  logic              rx_done;
  logic              err_ev;
  logic [7:0]        max_pos;
  logic [7:0]        max_dly;
  logic              ring_active;
  logic              ring_wake;
  logic              rx;
  logic              wake_rx;
  logic [7:0]        frames;
  logic [7:0]        rdata;
  logic              int_b;
  logic              status;
  logic              rxp_b;
  logic              wake_tx;
  logic              sect_en;
  logic              xcv_en;
  logic              soft_rst;
  logic              bypass;
  logic              saw_soft;
  logic [7:0]        d;
  int                n_errors = 0;
  int                samples_checked = 0;
  int                cycles = 0;

  pwc_power_ctrl i_pwc_power_ctrl (
    .I_CLOCK(clk), .I_RST_B(rst_b), .I_BUS(bus), .I_RX(rx), .I_SDA(sda),
    .I_CS_B(cs_b), .I_WR_B(wr_b), .I_PORT_MODE(port_mode),
    .I_WAKE_FRAME_RX(wake_rx), .I_MSG_TX_DONE(tx_done),
    .I_MSG_RX_DONE(rx_done), .I_ERR_EVENT(err_ev), .I_MAX_POSITION(max_pos),
    .I_MAX_DELAY(max_dly), .O_RDATA(rdata), .O_INT_B(int_b),
    .O_STATUS(status), .O_RX_POWER_B(rxp_b), .O_WAKE_FRAME_TX(wake_tx),
    .O_SECTION_EN(sect_en), .O_TRANSCEIVER_EN(xcv_en),
    .O_SOFT_RESET(soft_rst), .O_SYNC_BYPASS(bypass));

  pwc_ring_model i_pwc_ring_model (
    .i_clk(clk), .i_rst_b(rst_b), .i_active(ring_active), .i_wake(ring_wake),
    .i_wake_tx(wake_tx), .o_rx(rx), .o_wake_rx(wake_rx), .o_frames(frames));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    saw_soft <= saw_soft | (soft_rst === 1'b1);
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk);
    bus.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    v = rdata;
    bus.rd = 1'b0;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return int_b;
      1: return status;
      2: return sect_en;
      default: return wake_tx;
    endcase
  endfunction

  task automatic wait_sig(input int s, input logic v, input int lim);
    for (int i = 0; i < lim && pick(s) !== v; i++) @(negedge clk);
    chk({7'h00, pick(s)}, {7'h00, v});
  endtask

  // One falling edge on the line that the selected port mode watches
  task automatic port_edge;
    @(negedge clk);
    sda  = port_mode != 2'h0;
    cs_b = port_mode != 2'h1;
    wr_b = port_mode != 2'h2;
    repeat (3) @(negedge clk);
    sda  = 1'b1;
    cs_b = 1'b1;
    wr_b = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  task automatic pulse_ev(input int b);
    @(negedge clk);
    case (b)
      0: rx_done = 1'b1;
      1: tx_done = 1'b1;
      2: err_ev = 1'b1;
      default: max_dly = max_dly + 8'h01;
    endcase
    @(negedge clk);
    rx_done = 1'b0;
    tx_done = 1'b0;
    err_ev  = 1'b0;
  endtask

  task automatic clear_all;
    wr(8'h85, 8'h1f);
    wait_sig(0, 1'b1, 6);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    wait_sig(0, 1'b0, 4);
    chk({7'h00, status}, 8'h00);
    chk({7'h00, rxp_b}, 8'h00);
    clear_all();
    rd(8'h88, d);
    chk(d, 8'h00);
  endtask

  task automatic t_ie_reg;
    wr(8'h88, 8'hff);
    rd(8'h88, d);
    chk(d, 8'h0f);
    wr(8'h88, 8'h00);
    rd(8'h88, d);
    chk(d, 8'h00);
  endtask

  task automatic t_gating;
    for (int b = 0; b < 4; b++) begin
      wr(8'h88, ~(8'h01 << b) & 8'h0f);
      pulse_ev(b);
      repeat (6) @(negedge clk);
      chk({7'h00, int_b}, 8'h01);
      wr(8'h88, 8'h01 << b);
      wait_sig(0, 1'b0, 6);
      rd(8'h86, d);
      chk(d & 8'h0f, 8'h01 << b);
      wr(8'h85, 8'h01 << b);
      wait_sig(0, 1'b1, 6);
    end
    wr(8'h88, 8'h00);
  endtask

  task automatic t_multi;
    wr(8'h88, 8'h0f);
    max_pos = max_pos + 8'h01;
    wait_sig(0, 1'b0, 8);
    pulse_ev(1);
    wr(8'h85, 8'h08);
    wait_sig(0, 1'b1, 4);
    wait_sig(0, 1'b0, 4);
    wr(8'h85, 8'h02);
    wait_sig(0, 1'b1, 6);
    wr(8'h88, 8'h00);
  endtask

  task automatic t_activity;
    ring_active = 1'b1;
    repeat (10) @(negedge clk);
    rd(8'h8e, d);
    chk(d & 8'h40, 8'h40);
    ring_active = 1'b0;
    repeat (14) @(negedge clk);
    rd(8'h8e, d);
    chk(d & 8'h40, 8'h00);
  endtask

  task automatic t_wake_tx;
    wr(8'h80, 8'h82);
    wait_sig(3, 1'b1, 6);
    repeat (3) @(negedge clk);
    chk(frames, 8'h01);
    wr(8'h80, 8'h00);
  endtask

  task automatic t_low_power(input bit by_frame, input logic [1:0] pm);
    port_mode = pm;
    if (!by_frame) port_edge();
    wr(8'h8e, 8'h10);
    wait_sig(2, 1'b0, 6);
    chk({7'h00, xcv_en}, 8'h01);
    @(negedge clk);
    chk({7'h00, bypass}, 8'h01);
    saw_soft = 1'b0;
    if (by_frame) begin
      @(negedge clk);
      ring_wake = 1'b1;
      @(negedge clk);
      ring_wake = 1'b0;
    end else begin
      port_edge();
      repeat (20) @(negedge clk);
      chk({7'h00, sect_en}, 8'h00);
      port_edge();
    end
    wait_sig(2, 1'b1, 60);
    wait_sig(0, 1'b0, 20);
    chk({7'h00, saw_soft}, 8'h01);
    chk({7'h00, bypass}, 8'h01);
    rd(8'h86, d);
    chk(d & 8'h04, 8'h04);
    rd(8'h8e, d);
    chk(d & 8'h30, 8'h00);
    clear_all();
    wr(8'h80, 8'h00);
  endtask

  task automatic t_zero_power;
    port_mode   = 2'h1;
    ring_active = 1'b1;
    repeat (10) @(negedge clk);
    wr(8'h8e, 8'h20);
    wait_sig(2, 1'b0, 6);
    repeat (20) @(negedge clk);
    chk({7'h00, status}, 8'h00);
    ring_active = 1'b0;
    wait_sig(1, 1'b1, 40);
    chk({7'h00, rxp_b}, 8'h01);
    chk({7'h00, xcv_en}, 8'h00);
    port_edge();
    port_edge();
    wait_sig(1, 1'b0, 60);
    chk({7'h00, rxp_b}, 8'h00);
    wait_sig(0, 1'b0, 30);
    rd(8'h86, d);
    chk(d & 8'h14, 8'h14);
    clear_all();
    wr(8'h80, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b       = 1'b0;
    bus         = '0;
    cs_b        = 1'b1;
    sda         = 1'b1;
    wr_b        = 1'b1;
    port_mode   = 2'h1;
    tx_done     = 1'b0;
    rx_done     = 1'b0;
    err_ev      = 1'b0;
    max_pos     = 8'h00;
    max_dly     = 8'h00;
    ring_active = 1'b0;
    ring_wake   = 1'b0;
    saw_soft    = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, int_b}, 8'h01);
    rst_b = 1'b1;
    t_reset();
    t_ie_reg();
    t_gating();
    t_multi();
    t_activity();
    t_wake_tx();
    t_low_power(1'b1, 2'h1);
    t_low_power(1'b0, 2'h0);
    t_low_power(1'b0, 2'h1);
    t_low_power(1'b0, 2'h2);
    t_zero_power();
    results();
  end
endmodule

`default_nettype wire
